// *** src/ccu_pkg.sv ***
// constants and shared helpers of the crc calculation unit
package ccu_pkg;

  localparam int unsigned ADDR_W = 5;

  localparam logic [ADDR_W-1:0] OFF_DATA  = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_SPARE = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_CTRL  = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_INIT  = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_POLY  = 5'h14;

  localparam logic [31:0] RST_DATA  = 32'hFFFFFFFF;
  localparam logic [31:0] RST_INIT  = 32'hFFFFFFFF;
  localparam logic [31:0] RST_POLY  = 32'h04C11DB7;
  localparam logic [7:0]  RST_SPARE = 8'h00;
  localparam logic [7:0]  RST_CTRL  = 8'h00;

  // control register field positions
  localparam int unsigned CTRL_RESET_BIT = 0;
  localparam int unsigned CTRL_PW_LSB    = 3;
  localparam int unsigned CTRL_RI_LSB    = 5;
  localparam int unsigned CTRL_RO_BIT    = 7;
  localparam logic [7:0]  CTRL_WR_MASK   = 8'hF8;

  // polynomial width select codes
  localparam logic [1:0] PW_32 = 2'h0;
  localparam logic [1:0] PW_16 = 2'h1;
  localparam logic [1:0] PW_8  = 2'h2;
  localparam logic [1:0] PW_7  = 2'h3;

  // input reversal select codes
  localparam logic [1:0] RI_NONE = 2'h0;
  localparam logic [1:0] RI_BYTE = 2'h1;
  localparam logic [1:0] RI_HALF = 2'h2;
  localparam logic [1:0] RI_WORD = 2'h3;

  // bus encodings
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int unsigned HTRANS_ACT_BIT = 1;
  localparam logic        HRESP_OKAY     = 1'b0;

  localparam logic [2:0] BYTES_1 = 3'h1;
  localparam logic [2:0] BYTES_2 = 3'h2;
  localparam logic [2:0] BYTES_4 = 3'h4;

  // index of the top checksum bit for a width code
  function automatic logic [4:0] width_msb(input logic [1:0] pw);
    logic [4:0] m;
    case (pw)
      PW_16:   m = 5'h0F;
      PW_8:    m = 5'h07;
      PW_7:    m = 5'h06;
      default: m = 5'h1F;
    endcase
    return m;
  endfunction : width_msb

  // ones over the selected checksum width
  function automatic logic [31:0] width_mask(input logic [4:0] m);
    logic [31:0] one;
    one = 32'h00000001;
    return (one << ({27'h0000000, m} + 32'h00000001)) - one;
  endfunction : width_mask

endpackage : ccu_pkg

// *** src/ccu_crc_engine.sv ***
// byte-serial checksum engine: one byte per clock, msb first
module ccu_crc_engine (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        load,
  input  wire logic [31:0] load_value,
  input  wire logic        start,
  input  wire logic [31:0] start_data,
  input  wire logic [2:0]  start_bytes,
  input  wire logic [31:0] poly,
  input  wire logic [4:0]  msb,
  output logic      [31:0] crc,
  output logic             busy,
  output logic             ready
);

  logic [31:0] crc_ff;
  logic [31:0] nxt_crc;
  logic [31:0] sh_ff;
  logic [31:0] nxt_sh;
  logic [2:0]  cnt_ff;
  logic [2:0]  nxt_cnt;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b,
                                           input logic [31:0] p, input logic [4:0] m);
    logic [31:0] r;
    logic        fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[m] ^ b[i];
      r  = r << 1;
      if (fb) begin
        r = r ^ p;
      end
    end
    return r & ccu_pkg::width_mask(m);
  endfunction : crc_byte

  always_comb begin
    nxt_crc = crc_ff;
    nxt_sh  = sh_ff;
    nxt_cnt = cnt_ff;
    if (load) begin
      nxt_crc = load_value;
      nxt_cnt = 3'h0;
    end else begin
      if (cnt_ff != 3'h0) begin
        nxt_crc = crc_byte(crc_ff, sh_ff[31:24], poly, msb);
        nxt_sh  = sh_ff << 8;
        nxt_cnt = cnt_ff - 3'h1;
      end
      if (start) begin
        nxt_sh  = start_data;
        nxt_cnt = start_bytes;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_ff <= ccu_pkg::RST_DATA;
      sh_ff  <= 32'h00000000;
      cnt_ff <= 3'h0;
    end else begin
      crc_ff <= nxt_crc;
      sh_ff  <= nxt_sh;
      cnt_ff <= nxt_cnt;
    end
  end

  assign crc   = crc_ff;
  assign busy  = (cnt_ff != 3'h0);
  // a new word may start in the last byte cycle of the current one
  assign ready = (cnt_ff <= 3'h1);

endmodule : ccu_crc_engine

// *** src/crc_calculation_unit.sv ***
// crc calculation unit: ahb-lite register slave with input buffer and checksum engine
// Functional notes
// - each data register write is folded into the held checksum
// - data register read returns last completed checksum, not written data
// - narrow data and checksum sit in the low bits of the data register
// - eight-bit spare byte in low bits, untouched by checksum reload
// - output reversal bit one bit-reverses the checksum on reads
// - input reversal field: none, per byte, per half-word, whole word
// - width field: 00 32 bits, 01 16, 10 8, 11 7 bits
// - writing control reset bit reloads checksum from the initial value register
// - reset bit is set by software only and cleared by hardware
// - 32-bit initial value register, resets to all ones
// - 32-bit polynomial register, resets to 04C11DB7
// - word takes four cycles, half-word two, byte one
// - input buffer takes a second write without wait states
// - writing the initial value register also loads the checksum
module crc_calculation_unit (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       hsel,
  input  wire logic [ccu_pkg::ADDR_W-1:0] haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp
);

  logic                       ph_wr_ff;
  logic                       nxt_ph_wr;
  logic                       ph_rd_ff;
  logic                       nxt_ph_rd;
  logic [ccu_pkg::ADDR_W-1:0] ph_addr_ff;
  logic [ccu_pkg::ADDR_W-1:0] nxt_ph_addr;
  logic [2:0]                 ph_size_ff;
  logic [2:0]                 nxt_ph_size;
  logic                       rd_done_ff;
  logic                       nxt_rd_done;
  logic [31:0]                hrdata_ff;
  logic [31:0]                nxt_hrdata;
  logic [7:0]                 spare_ff;
  logic [7:0]                 nxt_spare;
  logic [7:0]                 ctrl_ff;
  logic [7:0]                 nxt_ctrl;
  logic [31:0]                init_ff;
  logic [31:0]                nxt_init;
  logic [31:0]                poly_ff;
  logic [31:0]                nxt_poly;
  logic                       buf_vld_ff;
  logic                       nxt_buf_vld;
  logic [31:0]                buf_data_ff;
  logic [31:0]                nxt_buf_data;
  logic [2:0]                 buf_bytes_ff;
  logic [2:0]                 nxt_buf_bytes;

  logic [31:0] eng_crc;
  logic        eng_busy;
  logic        eng_ready;
  logic        eng_load;
  logic [31:0] eng_load_val;
  logic        take;
  logic        dr_wr;
  logic        wr_stall;
  logic        rd_ok;
  logic        wr_go;
  logic        word_acc;
  logic        init_wr;
  logic [4:0]  msb;
  logic [31:0] rd_crc;

  function automatic logic [31:0] bitrev32(input logic [31:0] d);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) begin
      r[i] = d[31-i];
    end
    return r;
  endfunction : bitrev32

  // reverse input bits at the chosen grain, never coarser than the access
  function automatic logic [31:0] prep_data(input logic [31:0] d, input logic [1:0] ri,
                                            input logic [2:0] sz);
    logic [31:0] m;
    logic [31:0] w;
    logic [1:0]  g;
    logic [31:0] r;
    case (sz)
      ccu_pkg::HSIZE_BYTE: m = {24'h000000, d[7:0]};
      ccu_pkg::HSIZE_HALF: m = {16'h0000, d[15:0]};
      default:             m = d;
    endcase
    g = ri;
    if (sz == ccu_pkg::HSIZE_BYTE && g != ccu_pkg::RI_NONE) begin
      g = ccu_pkg::RI_BYTE;
    end else if (sz == ccu_pkg::HSIZE_HALF && g == ccu_pkg::RI_WORD) begin
      g = ccu_pkg::RI_HALF;
    end
    w = bitrev32(m);
    case (g)
      ccu_pkg::RI_BYTE: r = {w[7:0], w[15:8], w[23:16], w[31:24]};
      ccu_pkg::RI_HALF: r = {w[15:0], w[31:16]};
      ccu_pkg::RI_WORD: r = w;
      default:          r = m;
    endcase
    // left-align so the engine always takes the top byte first
    case (sz)
      ccu_pkg::HSIZE_BYTE: r = r << 24;
      ccu_pkg::HSIZE_HALF: r = r << 16;
      default:             r = r;
    endcase
    return r;
  endfunction : prep_data

  function automatic logic [2:0] size_bytes(input logic [2:0] sz);
    logic [2:0] b;
    case (sz)
      ccu_pkg::HSIZE_BYTE: b = ccu_pkg::BYTES_1;
      ccu_pkg::HSIZE_HALF: b = ccu_pkg::BYTES_2;
      default:             b = ccu_pkg::BYTES_4;
    endcase
    return b;
  endfunction : size_bytes

  ccu_crc_engine ccu_crc_engine_inst (
    .clk         (clk),
    .rst_n       (rst_n),
    .load        (eng_load),
    .load_value  (eng_load_val),
    .start       (take),
    .start_data  (buf_data_ff),
    .start_bytes (buf_bytes_ff),
    .poly        (poly_ff),
    .msb         (msb),
    .crc         (eng_crc),
    .busy        (eng_busy),
    .ready       (eng_ready)
  );

  assign msb = ccu_pkg::width_msb(ctrl_ff[ccu_pkg::CTRL_PW_LSB +: 2]);
  assign rd_crc = ctrl_ff[ccu_pkg::CTRL_RO_BIT] ?
                  (bitrev32(eng_crc) >> (5'h1F - msb)) :
                  (eng_crc & ccu_pkg::width_mask(msb));

  always_comb begin
    dr_wr    = ph_wr_ff && (ph_addr_ff == ccu_pkg::OFF_DATA);
    word_acc = (ph_size_ff == ccu_pkg::HSIZE_WORD);
    init_wr  = ph_wr_ff && hready && word_acc && (ph_addr_ff == ccu_pkg::OFF_INIT);
    eng_load = init_wr || ctrl_ff[ccu_pkg::CTRL_RESET_BIT];
    eng_load_val = init_wr ? hwdata : init_ff;
    take     = buf_vld_ff && eng_ready && !eng_load;
    // reload stands in for eng_load here: keeps hready out of the stall path
    wr_stall = dr_wr && buf_vld_ff &&
               !(eng_ready && !ctrl_ff[ccu_pkg::CTRL_RESET_BIT]);
    // the checksum is only shown once all queued data is folded in
    rd_ok    = ph_rd_ff && !rd_done_ff &&
               ((ph_addr_ff != ccu_pkg::OFF_DATA) || (!eng_busy && !buf_vld_ff));
    wr_go    = ph_wr_ff && hready && !wr_stall;
    hreadyout = !(wr_stall || (ph_rd_ff && !rd_done_ff));
  end

  always_comb begin
    nxt_ph_wr     = ph_wr_ff;
    nxt_ph_rd     = ph_rd_ff;
    nxt_ph_addr   = ph_addr_ff;
    nxt_ph_size   = ph_size_ff;
    nxt_rd_done   = rd_done_ff;
    nxt_hrdata    = hrdata_ff;
    nxt_spare     = spare_ff;
    nxt_ctrl      = ctrl_ff;
    nxt_init      = init_ff;
    nxt_poly      = poly_ff;
    nxt_buf_vld   = buf_vld_ff;
    nxt_buf_data  = buf_data_ff;
    nxt_buf_bytes = buf_bytes_ff;

    if (hready) begin
      nxt_ph_wr   = hsel && htrans[ccu_pkg::HTRANS_ACT_BIT] && hwrite;
      nxt_ph_rd   = hsel && htrans[ccu_pkg::HTRANS_ACT_BIT] && !hwrite;
      nxt_ph_addr = haddr;
      nxt_ph_size = hsize;
      nxt_rd_done = 1'b0;
    end else if (rd_ok) begin
      nxt_rd_done = 1'b1;
    end

    if (rd_ok) begin
      case (ph_addr_ff)
        ccu_pkg::OFF_DATA:  nxt_hrdata = rd_crc;
        ccu_pkg::OFF_SPARE: nxt_hrdata = {24'h000000, spare_ff};
        ccu_pkg::OFF_CTRL:  nxt_hrdata = {24'h000000, ctrl_ff};
        ccu_pkg::OFF_INIT:  nxt_hrdata = init_ff;
        ccu_pkg::OFF_POLY:  nxt_hrdata = poly_ff;
        default:            nxt_hrdata = 32'h00000000;
      endcase
    end

    // the reload takes one cycle, then hardware drops the bit
    if (ctrl_ff[ccu_pkg::CTRL_RESET_BIT]) begin
      nxt_ctrl[ccu_pkg::CTRL_RESET_BIT] = 1'b0;
    end

    if (take || eng_load) begin
      nxt_buf_vld = 1'b0;
    end

    if (wr_go) begin
      case (ph_addr_ff)
        ccu_pkg::OFF_DATA: begin
          nxt_buf_vld   = 1'b1;
          nxt_buf_data  = prep_data(hwdata, ctrl_ff[ccu_pkg::CTRL_RI_LSB +: 2], ph_size_ff);
          nxt_buf_bytes = size_bytes(ph_size_ff);
        end
        ccu_pkg::OFF_SPARE: begin
          if (word_acc) begin
            nxt_spare = hwdata[7:0];
          end
        end
        ccu_pkg::OFF_CTRL: begin
          if (word_acc) begin
            nxt_ctrl = (hwdata[7:0] & ccu_pkg::CTRL_WR_MASK) |
                       {7'h00, hwdata[ccu_pkg::CTRL_RESET_BIT]};
          end
        end
        ccu_pkg::OFF_INIT: begin
          if (word_acc) begin
            nxt_init = hwdata;
          end
        end
        ccu_pkg::OFF_POLY: begin
          if (word_acc) begin
            nxt_poly = hwdata;
          end
        end
        default: begin
          nxt_poly = poly_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_wr_ff     <= 1'b0;
      ph_rd_ff     <= 1'b0;
      ph_addr_ff   <= ccu_pkg::OFF_DATA;
      ph_size_ff   <= ccu_pkg::HSIZE_WORD;
      rd_done_ff   <= 1'b0;
      hrdata_ff    <= 32'h00000000;
      spare_ff     <= ccu_pkg::RST_SPARE;
      ctrl_ff      <= ccu_pkg::RST_CTRL;
      init_ff      <= ccu_pkg::RST_INIT;
      poly_ff      <= ccu_pkg::RST_POLY;
      buf_vld_ff   <= 1'b0;
      buf_data_ff  <= 32'h00000000;
      buf_bytes_ff <= 3'h0;
    end else begin
      ph_wr_ff     <= nxt_ph_wr;
      ph_rd_ff     <= nxt_ph_rd;
      ph_addr_ff   <= nxt_ph_addr;
      ph_size_ff   <= nxt_ph_size;
      rd_done_ff   <= nxt_rd_done;
      hrdata_ff    <= nxt_hrdata;
      spare_ff     <= nxt_spare;
      ctrl_ff      <= nxt_ctrl;
      init_ff      <= nxt_init;
      poly_ff      <= nxt_poly;
      buf_vld_ff   <= nxt_buf_vld;
      buf_data_ff  <= nxt_buf_data;
      buf_bytes_ff <= nxt_buf_bytes;
    end
  end

  assign hrdata = hrdata_ff;
  assign hresp  = ccu_pkg::HRESP_OKAY;

endmodule : crc_calculation_unit

// *** test/ccu_chk.sv ***
// bus protocol and register map assertions for the crc calculation unit
module ccu_chk (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic                       hsel,
  input wire logic [ccu_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic                       hready,
  input wire logic [31:0]                hrdata,
  input wire logic                       hreadyout,
  input wire logic                       hresp
);
  logic                       take;
  logic                       dp_ff, nxt_dp, first_ff, nxt_first, wr_ff, nxt_wr;
  logic [ccu_pkg::ADDR_W-1:0] adr_ff, nxt_adr;
  logic                       rd_done;

  // data phase tracker
  always_comb begin
    take      = hsel & htrans[ccu_pkg::HTRANS_ACT_BIT] & hready;
    nxt_first = take;
    nxt_dp    = take | (dp_ff & ~hreadyout);
    nxt_wr    = take ? hwrite : wr_ff;
    nxt_adr   = take ? haddr : adr_ff;
    rd_done   = dp_ff & ~wr_ff & hreadyout;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_ff    <= 1'b0;
      first_ff <= 1'b0;
      wr_ff    <= 1'b0;
      adr_ff   <= 5'h00;
    end else begin
      dp_ff    <= nxt_dp;
      first_ff <= nxt_first;
      wr_ff    <= nxt_wr;
      adr_ff   <= nxt_adr;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_IDLE_READY: assert property (!dp_ff |-> hreadyout)
    else $error("wait state outside a data phase");
  AST_RESP_OKAY: assert property (hresp == ccu_pkg::HRESP_OKAY)
    else $error("error response");
  AST_REG_WR_NOWAIT: assert property (first_ff && wr_ff && adr_ff != 5'h00 |-> hreadyout)
    else $error("register write stalled");
  AST_DATA_WR_BOUND: assert property (first_ff && wr_ff |-> ##[0:3] hreadyout)
    else $error("data write stalled too long");
  AST_RD_WAIT: assert property (first_ff && !wr_ff |-> !hreadyout)
    else $error("read without capture cycle");
  AST_RD_BOUND: assert property (first_ff && !wr_ff |-> ##[1:12] hreadyout)
    else $error("read stalled too long");
  AST_SPARE_RSV: assert property (rd_done && adr_ff == 5'h04 |-> hrdata[31:8] == 24'h000000)
    else $error("spare upper bits not zero");
  AST_CTRL_RSV: assert property (rd_done && adr_ff == 5'h08 |-> !hrdata[31:8] && !hrdata[2:1])
    else $error("control reserved bits not zero");
  AST_UNMAPPED: assert property (rd_done && adr_ff == 5'h0C |-> hrdata == 32'h00000000)
    else $error("unmapped read not zero");

  cover property (first_ff && !wr_ff && adr_ff == 5'h00);
  cover property (first_ff && wr_ff && adr_ff == 5'h10);
  cover property (rd_done && adr_ff == 5'h08);
endmodule : ccu_chk

bind crc_calculation_unit ccu_chk ccu_chk_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp));

// *** test/ccu_ahb_host.sv ***
// bus host model driving the register port of the crc unit
module ccu_ahb_host (
  input  wire logic        clk,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [4:0]       haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hsel   = 1'b0;
    haddr  = 5'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h00000000;
  end

  // entered just after a rising edge, returns at the edge that ends the data phase
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [2:0] sz,
                      input logic [31:0] d, output logic [31:0] q, output int waits);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= a;
    hsize  <= sz;
    @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waits = 0;
    // sample where the outputs are settled; a hang is left to the watchdog
    @(negedge clk);
    while (hreadyout !== 1'b1) begin
      waits++;
      @(negedge clk);
    end
    q = hrdata;
    @(posedge clk);
  endtask : xfer
endmodule : ccu_ahb_host

// *** test/crc_calculation_unit_tb_top.sv ***
// self-checking bench for the crc calculation unit
module crc_calculation_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] AD_DATA = ccu_pkg::OFF_DATA;
  localparam logic [4:0] AD_SPARE = ccu_pkg::OFF_SPARE;
  localparam logic [4:0] AD_CTRL = ccu_pkg::OFF_CTRL;
  localparam logic [4:0] AD_INIT = ccu_pkg::OFF_INIT;
  localparam logic [4:0] AD_POLY = ccu_pkg::OFF_POLY;
  localparam logic [2:0] SZ_B = ccu_pkg::HSIZE_BYTE;
  localparam logic [2:0] SZ_H = ccu_pkg::HSIZE_HALF;
  localparam logic [31:0] POLY32 = 32'h04C11DB7;

  logic        clk = 1'b0;
  logic        rst_n;
  logic        hsel, hwrite, hreadyout, hresp;
  logic [4:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  int          err_count = 0;
  int          checks = 0;

  always #5 clk = ~clk;

  crc_calculation_unit crc_calculation_unit_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

  ccu_ahb_host ccu_ahb_host_inst (.clk(clk), .hreadyout(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));

  // reference: optional input reversal, then msb-first shift against top bit of width w
  function automatic logic [31:0] step(input logic [31:0] c, input logic [31:0] d,
                                       input logic [31:0] p, input int nb, input int ri,
                                       input int w);
    int          g;
    logic        t;
    logic [31:0] m, x;
    g = (ri == 0) ? 0 : 4 << ri;
    if (g > nb) g = nb;
    x = d;
    for (int i = 0; i < nb; i++) if (g != 0) x[i] = d[(i / g) * g + g - 1 - i % g];
    m = (w == 32) ? 32'hFFFFFFFF : (32'h00000001 << w) - 32'h00000001;
    for (int i = nb - 1; i >= 0; i--) begin
      t = c[w - 1] ^ x[i];
      c = (c << 1) & m;
      if (t) c = (c ^ p) & m;
    end
    return c;
  endfunction : step

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t ns: read %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [2:0] sz = 3'h2);
    logic [31:0] q;
    int          w;
    ccu_ahb_host_inst.xfer(1'b1, a, sz, d, q, w);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    int w;
    ccu_ahb_host_inst.xfer(1'b0, a, 3'h2, 32'h00000000, q, w);
  endtask : rd

  task automatic t_regs();
    logic [4:0]  ra [6];
    logic [31:0] rv [6];
    logic [31:0] q;
    ra = '{AD_DATA, AD_SPARE, AD_CTRL, AD_INIT, AD_POLY, 5'h0C};
    rv = '{32'hFFFFFFFF, 32'h00000000, 32'h00000000, 32'hFFFFFFFF, POLY32, 32'h00000000};
    wr(5'h0C, 32'h0000FFFF);
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], q);
      chk(q, rv[i]);
    end
  endtask : t_regs

  task automatic t_stream();
    logic [31:0] q, c;
    int          w0, w1;
    wr(AD_CTRL, 32'h00000000);
    wr(AD_INIT, 32'hFFFFFFFF);
    ccu_ahb_host_inst.xfer(1'b1, AD_DATA, 3'h2, 32'h1A2B3C4D, q, w0);
    ccu_ahb_host_inst.xfer(1'b1, AD_DATA, 3'h2, 32'h5E6F7081, q, w1);
    chk(32'(w0 + w1), 32'h00000000);
    c = step(32'hFFFFFFFF, 32'h1A2B3C4D, POLY32, 32, 0, 32);
    c = step(c, 32'h5E6F7081, POLY32, 32, 0, 32);
    rd(AD_DATA, q);
    chk(q, c);
  endtask : t_stream

  task automatic t_width();
    logic [31:0] pl [4];
    logic [31:0] q, c, rv;
    int          w;
    pl = '{POLY32, 32'h00001021, 32'h00000007, 32'h00000009};
    for (int pw = 0; pw < 4; pw++) begin
      w = (pw == 0) ? 32 : (pw == 1) ? 16 : (pw == 2) ? 8 : 7;
      wr(AD_CTRL, {27'h0000000, 2'(pw), 3'h0});
      wr(AD_POLY, pl[pw]);
      wr(AD_INIT, 32'h0000005A);
      wr(AD_DATA, 32'h000000C3, SZ_B);
      wr(AD_DATA, 32'h0000BEEF, SZ_H);
      wr(AD_DATA, 32'h1A2B3C4D);
      c = step(32'h0000005A, 32'h000000C3, pl[pw], 8, 0, w);
      c = step(c, 32'h0000BEEF, pl[pw], 16, 0, w);
      c = step(c, 32'h1A2B3C4D, pl[pw], 32, 0, w);
      rd(AD_DATA, q);
      chk(q, c);
      wr(AD_CTRL, {24'h000000, 1'b1, 2'h0, 2'(pw), 3'h0});
      rd(AD_DATA, q);
      rv = {<<{c}};
      chk(q, rv >> (32 - w));
    end
    wr(AD_POLY, POLY32);
  endtask : t_width

  task automatic t_rev();
    logic [31:0] q, c;
    for (int ri = 0; ri < 4; ri++) begin
      wr(AD_CTRL, {24'h000000, 1'b1, 2'(ri), 5'h00});
      wr(AD_INIT, 32'hFFFFFFFF);
      wr(AD_DATA, 32'h0000001A, SZ_B);
      wr(AD_DATA, 32'h1A2B3C4D);
      wr(AD_DATA, 32'h00002B3C, SZ_H);
      c = step(32'hFFFFFFFF, 32'h0000001A, POLY32, 8, ri, 32);
      c = step(c, 32'h1A2B3C4D, POLY32, 32, ri, 32);
      c = step(c, 32'h00002B3C, POLY32, 16, ri, 32);
      rd(AD_DATA, q);
      chk(q, {<<{c}});
    end
  endtask : t_rev

  task automatic t_reload();
    logic [31:0] q;
    wr(AD_CTRL, 32'h00000000);
    wr(AD_SPARE, 32'h000000A5);
    wr(AD_INIT, 32'h12345678);
    rd(AD_DATA, q);
    chk(q, 32'h12345678);
    wr(AD_DATA, 32'h1A2B3C4D);
    wr(AD_CTRL, 32'h00000000);
    rd(AD_DATA, q);
    chk(q, step(32'h12345678, 32'h1A2B3C4D, POLY32, 32, 0, 32));
    wr(AD_DATA, 32'h1A2B3C4D);
    wr(AD_CTRL, 32'h00000001);
    rd(AD_DATA, q);
    chk(q, 32'h12345678);
    rd(AD_CTRL, q);
    chk(q, 32'h00000000);
    rd(AD_SPARE, q);
    chk(q, 32'h000000A5);
  endtask : t_reload

  task automatic summarize();
    if (err_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  initial begin
    #100us;
    err_count++;
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_stream();
    t_width();
    t_rev();
    t_reload();
    summarize();
  end
endmodule : crc_calculation_unit_tb_top
